// ### rtl/asr_receiver.sv
// Asynchronous serial receiver with two-entry FIFO and Avalon-MM register slave.
// Assumes a remote transmitter idles the line high; one 10 MHz clock, async active-low reset.
//
// Behaviour
// (RQ1) Falling edge while idle starts a character
// (RQ2) Start not low at centre: silent abort
// (RQ3) Full bit steps, majority vote, shift in
// (RQ4) Low stop sample marks framing error
// (RQ5) After stop, push character, raise pending
// (RQ6) Data read returns and pops oldest
// (RQ7) Pending equals enabled and FIFO nonempty
// (RQ8) Interrupt needs pending and three enables
// (RQ9) Framing bit stored per entry, head shown
// (RQ10) Framing error never blocks; pop advances it
// (RQ11) Port disable clears framing; no interrupt
// (RQ12) Third character into full FIFO: overrun
// (RQ13) Overrun blocks pushes; enables clear it
// (RQ14) Nine-bit mode shifts nine; ninth exposed
// (RQ15) Address detect keeps ninth-bit-set characters only; filters in nine-bit mode only, eight-bit mode keeps all
// (RQ16) Software drops address detect after match
// (RQ17) Software enables port, then reception
// (RQ18) Status shows errors and ninth bit
// (RQ19) Data assembled least significant first
// (RQ20) Sixteen ticks per bit, one shift
// (RQ21) Active only with both enables, async mode
// (RQ22) Vote over three ticks around centre
`timescale 1ns/1ps
`include "asr_consts.svh"
module asr_receiver (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  input  wire logic        receive_line_in,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic             irq_out
);
  asr_samp_if samp ();

  asr_sampler u_sampler (
    .clk_sys_in      (clk_sys_in),
    .reset_n_in      (reset_n_in),
    .receive_line_in (receive_line_in),
    .samp            (samp)
  );

  logic [7:0]         ctrl;
  logic [15:0]        baud;
  logic               ack_q;
  logic               pop_arm;
  asr_pkg::asr_state_e state;
  logic [3:0]         tick_cnt;
  logic [3:0]         bit_cnt;
  logic [8:0]         receive_shift_register;
  logic [9:0]         fifo_mem [2];
  logic               rd_ptr;
  logic               wr_ptr;
  logic [1:0]         count;
  logic               overrun_error_flag;
  logic               line_prev;           // Line level at the previous tick, for edge search

  // Control fields
  wire port_enable                 = ctrl[`ASR_CTRL_PORT_EN];
  wire receive_enable              = ctrl[`ASR_CTRL_RX_EN];
  wire nine_bit_receive_select     = ctrl[`ASR_CTRL_NINE];
  wire address_detect_enable       = ctrl[`ASR_CTRL_ADDR];
  wire receive_interrupt_enable    = ctrl[`ASR_CTRL_RIE];
  wire peripheral_interrupt_enable = ctrl[`ASR_CTRL_PERIPHERAL_INTERRUPT_ENABLE];
  wire global_interrupt_enable     = ctrl[`ASR_CTRL_GIE];
  wire sync_mode                   = ctrl[`ASR_CTRL_SYNC];
  wire rx_active = port_enable & receive_enable & ~sync_mode; // RQ21

  // Sampler runs whenever the port is on
  assign samp.enable  = port_enable;
  assign samp.divisor = baud;

  // Bus decode; every access takes exactly one wait cycle so read data can be registered
  wire bus_req   = avs_read_in | avs_write_in;
  wire capture   = bus_req & ~ack_q;
  wire sel_ctrl  = (avs_address_in == `ASR_OFS_CTRL);
  wire sel_stat  = (avs_address_in == `ASR_OFS_STATUS);
  wire sel_data  = (avs_address_in == `ASR_OFS_DATA);
  wire sel_baud  = (avs_address_in == `ASR_OFS_BAUD);
  wire wr_ctrl   = ack_q & avs_write_in & sel_ctrl & avs_byteenable_in[0];
  wire wr_baud_l = ack_q & avs_write_in & sel_baud & avs_byteenable_in[0];
  wire wr_baud_h = ack_q & avs_write_in & sel_baud & avs_byteenable_in[1];
  wire pop       = ack_q & avs_read_in & pop_arm; // RQ6
  assign avs_waitrequest_out = bus_req & ~ack_q;

  // Head entry view: {framing, ninth, data}
  wire [9:0] head          = fifo_mem[rd_ptr];
  wire       fifo_nonempty = (count != 2'h0);
  wire       fifo_full     = (count == `ASR_FIFO_DEPTH);
  wire       framing_error_flag  = fifo_nonempty & head[9];           // RQ9
  wire       received_ninth_bit  = fifo_nonempty & head[8];           // RQ14
  wire       receive_pending_flag = rx_active & fifo_nonempty;        // RQ7
  wire       rx_idle = (state == asr_pkg::ASR_IDLE);

  // Status and read mux
  wire [31:0] status_word = {27'h0, rx_idle, receive_pending_flag, framing_error_flag,
                             overrun_error_flag, received_ninth_bit}; // RQ18
  wire [31:0] data_word   = fifo_nonempty ? {24'h0, head[7:0]} : 32'h0;
  wire [31:0] rd_mux      = sel_ctrl ? {24'h0, ctrl} :
                            sel_stat ? status_word :
                            sel_data ? data_word :
                            sel_baud ? {16'h0, baud} : 32'h0;

  // Interrupt request: framing errors alone never reach it
  assign irq_out = receive_pending_flag & receive_interrupt_enable &
                   peripheral_interrupt_enable & global_interrupt_enable; // RQ8 RQ11

  // Receiver timing decisions
  // Ticks are gated by the enables so a disable that lands on the stop tick cannot push
  wire tick        = samp.tick & rx_active;
  wire start_edge  = rx_idle & tick & ~samp.line & line_prev;           // RQ1
  wire start_check = (state == asr_pkg::ASR_START) & tick & (tick_cnt == `ASR_START_VOTE);
  wire bit_centre  = tick & (tick_cnt == `ASR_OVS_LAST);                // RQ20
  wire data_sample = (state == asr_pkg::ASR_DATA) & bit_centre;
  wire stop_sample = (state == asr_pkg::ASR_STOP) & bit_centre;
  wire [3:0] n_bits = nine_bit_receive_select ? (`ASR_DATA_BITS + 4'h1) : `ASR_DATA_BITS; // RQ14
  wire [8:0] char9  = nine_bit_receive_select ? receive_shift_register
                                              : {1'b0, receive_shift_register[8:1]};
  wire addr_reject  = address_detect_enable & nine_bit_receive_select & ~char9[8]; // RQ15
  wire accept       = stop_sample & ~addr_reject & ~overrun_error_flag;            // RQ13
  wire push         = accept & ~fifo_full;                                          // RQ5
  wire set_overrun  = accept & fifo_full;                                           // RQ12

  // Bus handshake and registered read data
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_q            <= 1'b0;
      pop_arm          <= 1'b0;
      avs_readdata_out <= 32'h0;
    end else begin
      ack_q <= capture;
      if (capture) begin
        avs_readdata_out <= avs_read_in ? rd_mux : 32'h0;
        pop_arm          <= avs_read_in & sel_data & fifo_nonempty;
      end
    end
  end

  // Software registers
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl <= `ASR_CTRL_RST;
      baud <= `ASR_BAUD_RST;
    end else begin
      if (wr_ctrl) ctrl <= avs_writedata_in[7:0];
      if (wr_baud_l) baud[7:0] <= avs_writedata_in[7:0];
      if (wr_baud_h) baud[15:8] <= avs_writedata_in[15:8];
    end
  end

  // Bit recovery state machine
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state     <= asr_pkg::ASR_IDLE;
      tick_cnt  <= 4'h0;
      bit_cnt   <= 4'h0;
      line_prev <= 1'b1;
      receive_shift_register <= 9'h000;
    end else if (!rx_active) begin
      state     <= asr_pkg::ASR_IDLE;
      tick_cnt  <= 4'h0;
      bit_cnt   <= 4'h0;
      line_prev <= 1'b1;
    end else begin
      if (tick) line_prev <= samp.line;
      if (tick && !rx_idle) tick_cnt <= tick_cnt + 4'h1;
      case (state)
        asr_pkg::ASR_IDLE: begin
          if (start_edge) begin
            state    <= asr_pkg::ASR_START; // RQ1
            tick_cnt <= 4'h0;
          end
        end
        asr_pkg::ASR_START: begin
          if (start_check) begin
            state    <= samp.vote ? asr_pkg::ASR_IDLE : asr_pkg::ASR_DATA; // RQ2 RQ22
            tick_cnt <= 4'h0;
            bit_cnt  <= 4'h0;
          end
        end
        asr_pkg::ASR_DATA: begin
          if (data_sample) begin
            receive_shift_register <= {samp.vote, receive_shift_register[8:1]}; // RQ3 RQ19
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt + 4'h1 == n_bits) state <= asr_pkg::ASR_STOP;
          end
        end
        asr_pkg::ASR_STOP: begin
          if (stop_sample) state <= asr_pkg::ASR_IDLE; // RQ10
        end
        default: state <= asr_pkg::ASR_IDLE;
      endcase
    end
  end

  // FIFO entry write; framing bit travels with its character
  // No reset: an entry is only shown while count says it holds data
  always_ff @(posedge clk_sys_in) begin
    if (push) fifo_mem[wr_ptr] <= {~samp.vote, char9}; // RQ4 RQ9
  end

  // FIFO pointers and overrun; port disable flushes everything, receive disable only overrun
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count  <= 2'h0;
      overrun_error_flag <= 1'b0;
    end else if (!port_enable) begin
      rd_ptr <= 1'b0; // RQ11
      wr_ptr <= 1'b0;
      count  <= 2'h0;
      overrun_error_flag <= 1'b0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr; // RQ6
      count <= count + {1'b0, push} - {1'b0, pop};
      if (set_overrun) overrun_error_flag <= 1'b1; // RQ12
      else if (!receive_enable) overrun_error_flag <= 1'b0; // RQ13
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  sequence seq_stop_ok;
    stop_sample && !overrun_error_flag && !addr_reject;
  endsequence
  sequence seq_pop_only;
    pop && !push;
  endsequence

  AST_START_ABORT: assert property (start_check && samp.vote |=> rx_idle && !push) // RQ2
    else $error("Start glitch did not abort");
  AST_START_GO: assert property (start_check && !samp.vote |=> state == asr_pkg::ASR_DATA && bit_cnt == 4'h0) // RQ3
    else $error("Confirmed start did not enter data");
  AST_PUSH: assert property (seq_stop_ok ##0 (count == 2'h1) && !pop && !wr_ctrl |=> count == 2'h2) // RQ5
    else $error("Stop sample did not load FIFO");
  AST_OVERRUN: assert property (seq_stop_ok ##0 fifo_full && !pop && !wr_ctrl // RQ12
                                |=> overrun_error_flag && count == 2'h2)
    else $error("Third character did not flag overrun");
  AST_OVR_HOLD: assert property (overrun_error_flag && !pop && !wr_ctrl |=> count == $past(count)) // RQ13
    else $error("Character accepted during overrun");
  AST_POP: assert property (seq_pop_only ##0 port_enable |=> count == $past(count) - 2'h1) // RQ6
    else $error("Data read did not pop");
  AST_PORT_OFF: assert property (!port_enable |=> count == 2'h0 && !overrun_error_flag && !framing_error_flag) // RQ11
    else $error("Port disable did not reset receiver");
  AST_IRQ: assert property (irq_out |-> receive_pending_flag && receive_interrupt_enable // RQ8
                            && peripheral_interrupt_enable && global_interrupt_enable)
    else $error("Interrupt without pending and enables");
  AST_ADDR: assert property (stop_sample && addr_reject && !pop && !wr_ctrl |=> count == $past(count)) // RQ15
    else $error("Address filter let a data character in");
  AST_TICK: assert property (tick && baud != 16'h0000 |=> !tick) // RQ20
    else $error("Sample ticks back to back");
  AST_BUS: assert property (capture |=> !avs_waitrequest_out) // RQ18
    else $error("Bus answer not after one wait cycle");

  // Frame stepping: a start needs a seen edge, and the bit count alone ends the data phase
  sequence seq_last8;
    data_sample && !nine_bit_receive_select && bit_cnt == 4'h7;
  endsequence
  sequence seq_last9;
    data_sample && nine_bit_receive_select && bit_cnt == 4'h8;
  endsequence

  AST_EDGE_GO: assert property (start_edge |=> state == asr_pkg::ASR_START) // RQ1
    else $error("Falling edge did not start");
  AST_HIGH_STAY: assert property (rx_idle && tick && samp.line |=> rx_idle) // RQ1
    else $error("Start without a low line");
  AST_START_WAIT: assert property (state == asr_pkg::ASR_START && tick && tick_cnt < `ASR_START_VOTE // RQ2
                                   |=> state == asr_pkg::ASR_START)
    else $error("Start decided before its centre");
  AST_EIGHT_BITS: assert property (seq_last8 |=> state == asr_pkg::ASR_STOP) // RQ3
    else $error("Eight-bit frame missed stop");
  AST_NINE_BITS: assert property (seq_last9 |=> state == asr_pkg::ASR_STOP) // RQ14
    else $error("Nine-bit frame missed stop");
  AST_MORE_BITS: assert property (data_sample && bit_cnt < 4'h7 |=> state == asr_pkg::ASR_DATA) // RQ3
    else $error("Data phase ended early");
  AST_SHIFT_LSB: assert property (data_sample |=> receive_shift_register[8] == $past(samp.vote)) // RQ19
    else $error("Voted bit not shifted in at the top");
  AST_STOP_END: assert property (stop_sample |=> rx_idle) // RQ10
    else $error("Receiver not idle after stop");

  // FIFO view: a push into an empty FIFO becomes the head at once
  sequence seq_push_empty;
    push && count == 2'h0 && !pop && !wr_ctrl;
  endsequence

  AST_FRAMING_ERROR_FLAG_SET: assert property (seq_push_empty ##0 !samp.vote |=> framing_error_flag) // RQ4
    else $error("Low stop did not flag framing");
  AST_FRAMING_ERROR_FLAG_CLR: assert property (seq_push_empty ##0 samp.vote |=> !framing_error_flag) // RQ4
    else $error("High stop flagged framing");
  AST_HEAD_DATA: assert property (seq_push_empty |=> head[8:0] == $past(char9)) // RQ5
    else $error("Head differs from received character");
  AST_PEND_RISE: assert property (seq_push_empty |=> receive_pending_flag) // RQ5
    else $error("Push did not raise pending");
  AST_NINE_TOP: assert property (seq_push_empty ##0 nine_bit_receive_select // RQ14
                                 |=> received_ninth_bit == $past(receive_shift_register[8]))
    else $error("Ninth bit not shown for head");
  AST_ADDR_KEEP: assert property (stop_sample && address_detect_enable && char9[8] // RQ15
                                  && !overrun_error_flag && !fifo_full |-> push)
    else $error("Address character not loaded");
  AST_POP_NONEMPTY: assert property (pop |-> fifo_nonempty) // RQ6
    else $error("Pop from empty FIFO");
  AST_COUNT_MAX: assert property (count != 2'h3) // RQ12
    else $error("FIFO count beyond two");

  // Enables: why a disable is safe at any moment, and that register writes other than control never move pending
  AST_OFF_NO_PUSH: assert property (!rx_active |-> !push) // RQ21
    else $error("Push while receiver inactive");
  AST_SYNC_IDLE: assert property (sync_mode |=> rx_idle) // RQ21
    else $error("Synchronous mode left receiver running");
  AST_PORT_IDLE: assert property (!port_enable |=> rx_idle && !samp.tick) // RQ21
    else $error("Port off but sampler still ticking");
  AST_PEND_OFF: assert property (!rx_active |-> !receive_pending_flag) // RQ7
    else $error("Pending while receiver inactive");
  AST_SW_PEND: assert property (ack_q && avs_write_in && !wr_ctrl && !push // RQ7
                                |=> receive_pending_flag == $past(receive_pending_flag))
    else $error("Register write moved pending");
  AST_RXOFF_KEEP: assert property (port_enable && !receive_enable && !pop && !wr_ctrl // RQ11
                                   |=> count == $past(count))
    else $error("Receive disable changed FIFO");
  AST_OVR_STICKY: assert property (overrun_error_flag && port_enable && receive_enable && !wr_ctrl // RQ13
                                   |=> overrun_error_flag)
    else $error("Overrun cleared while enabled");
  AST_RXOFF_OVR: assert property (port_enable && !receive_enable |=> !overrun_error_flag) // RQ13
    else $error("Receive disable kept overrun");
  AST_IRQ_ON: assert property (receive_pending_flag && receive_interrupt_enable // RQ8
                               && peripheral_interrupt_enable && global_interrupt_enable |-> irq_out)
    else $error("Enabled pending gave no interrupt");
  AST_IRQ_GIE: assert property (!global_interrupt_enable |-> !irq_out) // RQ8
    else $error("Interrupt with global enable off");
  AST_FRAMING_ERROR_FLAG_NO_IRQ: assert property (framing_error_flag && !receive_pending_flag |-> !irq_out) // RQ11
    else $error("Framing error alone raised interrupt");
endmodule : asr_receiver

// ### rtl/asr_consts.svh
// Offsets, field positions, reset values and timing counts of the serial receiver.
// Included by bare name; holds definitions only.
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH

// Word-aligned byte offsets on the register bus
`define ASR_OFS_CTRL      4'h0
`define ASR_OFS_STATUS    4'h4
`define ASR_OFS_DATA      4'h8
`define ASR_OFS_BAUD      4'hC

// Control register fields
`define ASR_CTRL_PORT_EN  0
`define ASR_CTRL_RX_EN    1
`define ASR_CTRL_SYNC     2
`define ASR_CTRL_NINE     3
`define ASR_CTRL_ADDR     4
`define ASR_CTRL_RIE      5
`define ASR_CTRL_PERIPHERAL_INTERRUPT_ENABLE     6
`define ASR_CTRL_GIE      7
`define ASR_CTRL_RST      8'h00

// Status register fields
`define ASR_ST_NINTH      0
`define ASR_ST_OVR        1
`define ASR_ST_FRAMING_ERROR_FLAG       2
`define ASR_ST_PEND       3
`define ASR_ST_IDLE       4

// Sample tick period in system clocks, minus one
`define ASR_BAUD_RST      16'h0040

// Oversampling: 16 ticks per bit, vote three ticks around the centre
`define ASR_OVS_LAST      4'hF
`define ASR_START_VOTE    4'h8
`define ASR_DATA_BITS     4'h8
`define ASR_FIFO_DEPTH    2'h2

`endif

// ### rtl/asr_pkg.sv
// Types shared by the serial receiver modules.
// Assumes nothing beyond a SystemVerilog compiler.
package asr_pkg;
  typedef enum logic [1:0] {
    ASR_IDLE,
    ASR_START,
    ASR_DATA,
    ASR_STOP
  } asr_state_e;
endpackage : asr_pkg

// ### rtl/asr_samp_if.sv
// Carrier between the receiver core and its line sampler.
// Assumes both ends run on the one system clock.
`timescale 1ns/1ps
interface asr_samp_if;
  logic        enable;      // Port enabled, tick divider runs
  logic [15:0] divisor;     // Tick period minus one
  logic        tick;        // One-cycle pulse, sixteen per bit
  logic        line;        // Line level at the latest tick
  logic        vote;        // Majority of the latest three tick samples

  modport sampler (input enable, input divisor, output tick, output line, output vote);
  modport core    (output enable, output divisor, input tick, input line, input vote);
endinterface : asr_samp_if

// ### rtl/asr_sampler.sv
// Line sampler: three-stage synchroniser, 16x tick divider and 2-of-3 majority.
// Assumes the receive line is asynchronous to clk_sys_in.
`timescale 1ns/1ps
`include "asr_consts.svh"
module asr_sampler (
  input  wire logic   clk_sys_in,
  input  wire logic   reset_n_in,
  input  wire logic   receive_line_in,
  asr_samp_if.sampler samp
);
  logic        sync_a;      // Metastable stage, read only by sync_b
  logic        sync_b;
  logic        sync_c;
  logic        line_level;
  logic [15:0] div_cnt;
  logic [2:0]  hist;
  logic        tick_q;

  wire div_wrap = (div_cnt >= samp.divisor);

  // Three flops; a change is taken only once the last two agree
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_a     <= 1'b1;
      sync_b     <= 1'b1;
      sync_c     <= 1'b1;
      line_level <= 1'b1;
    end else begin
      sync_a <= receive_line_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
      if (sync_b == sync_c) begin
        line_level <= sync_c;
      end
    end
  end

  // Tick divider; history and tick flop move together so the core sees a consistent vote
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_cnt <= 16'h0000;
      hist    <= 3'h7;
      tick_q  <= 1'b0;
    end else if (!samp.enable) begin
      div_cnt <= 16'h0000;
      hist    <= 3'h7;
      tick_q  <= 1'b0;
    end else begin
      div_cnt <= div_wrap ? 16'h0000 : div_cnt + 16'h0001;
      tick_q  <= div_wrap;
      if (div_wrap) begin
        hist <= {hist[1:0], line_level};
      end
    end
  end

  // Level seen in at least two of three ticks
  assign samp.tick = tick_q;
  assign samp.line = hist[0];
  assign samp.vote = (hist[0] & hist[1]) | (hist[1] & hist[2]) | (hist[0] & hist[2]);
endmodule : asr_sampler

// ### testbench/asr_line_model.sv
// Remote transmitter model: drives the receive line, idle high.
// Assumes one bit lasts BIT_CLKS system clocks.
`timescale 1ns/1ps
module asr_line_model #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic clk_sys_in,
  output logic      line_out
);
  initial line_out = 1'b1;

  // Start, data least significant first, stop; stop level selectable to force errors
  task automatic send(input logic [8:0] data, input logic nine, input logic stop_ok);
    logic [10:0] frame;
    int          n;
    frame = nine ? {stop_ok, data, 1'b0} : {1'b1, stop_ok, data[7:0], 1'b0};
    n     = nine ? 11 : 10;
    for (int i = 0; i <= n; i++) begin
      @(posedge clk_sys_in);
      line_out <= (i == n) ? 1'b1 : frame[i];  // Last slot is one idle bit
      repeat (BIT_CLKS - 1) @(posedge clk_sys_in);
    end
  endtask : send

  // Low pulse far shorter than half a bit, then a long idle
  task automatic glitch(input int clks);
    @(posedge clk_sys_in);
    line_out <= 1'b0;
    repeat (clks) @(posedge clk_sys_in);
    line_out <= 1'b1;
    repeat (BIT_CLKS * 12) @(posedge clk_sys_in);
  endtask : glitch
endmodule : asr_line_model

// ### testbench/test_async_serial_receiver.sv
// Self-checking bench of the serial receiver: register bus tasks and line traffic.
// Assumes BAUD is written to 1 (a tick every 2 clocks), so one bit lasts 32 system clocks.
`timescale 1ns/1ps
`include "asr_consts.svh"
module test_async_serial_receiver;
  localparam logic [31:0] C_EN  = (32'h1 << `ASR_CTRL_PORT_EN) | (32'h1 << `ASR_CTRL_RX_EN);
  localparam logic [31:0] C_PE  = 32'h1 << `ASR_CTRL_PORT_EN;
  localparam logic [31:0] C_MSK = (32'h1 << `ASR_CTRL_RIE) | (32'h1 << `ASR_CTRL_PERIPHERAL_INTERRUPT_ENABLE);
  localparam logic [31:0] C_GIE = 32'h1 << `ASR_CTRL_GIE;
  localparam logic [31:0] C_9   = 32'h1 << `ASR_CTRL_NINE;
  localparam logic [31:0] C_AD  = 32'h1 << `ASR_CTRL_ADDR;
  localparam logic [31:0] C_SY  = 32'h1 << `ASR_CTRL_SYNC;
  localparam int          LIMIT = 20000;

  logic        clk_sys_in;
  logic        reset_n_in;
  wire logic   receive_line;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        irq;
  int          err_count;
  int          compares;
  int          cycles;

  asr_receiver asr_receiver_i (
    .clk_sys_in          (clk_sys_in),
    .reset_n_in          (reset_n_in),
    .receive_line_in     (receive_line),
    .avs_address_in      (address),
    .avs_read_in         (read),
    .avs_write_in        (write),
    .avs_writedata_in    (writedata),
    .avs_byteenable_in   (4'hF),
    .avs_readdata_out    (readdata),
    .avs_waitrequest_out (waitrequest),
    .irq_out             (irq)
  );

  asr_line_model #(.BIT_CLKS(32)) asr_line_model_i (
    .clk_sys_in (clk_sys_in),
    .line_out   (receive_line)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  // Hang guard: a stuck handshake ends the run through the normal report
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_count++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One bus cycle; request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys_in);
    read      <= rd;
    write     <= ~rd;
    address   <= a;
    writedata <= d;
    do @(posedge clk_sys_in); while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b1, a, 32'h0, q);
    check(q, exp);
  endtask : rd_chk

  // Expected status word with the receiver idle
  function automatic logic [31:0] st(input logic p, input logic f, input logic o, input logic n);
    st = 32'h0;
    st[`ASR_ST_IDLE]  = 1'b1;
    st[`ASR_ST_PEND]  = p;
    st[`ASR_ST_FRAMING_ERROR_FLAG]  = f;
    st[`ASR_ST_OVR]   = o;
    st[`ASR_ST_NINTH] = n;
  endfunction : st

  task automatic t_reset_values();
    rd_chk(`ASR_OFS_CTRL, 32'h0);
    rd_chk(`ASR_OFS_BAUD, 32'h40);
    rd_chk(`ASR_OFS_STATUS, st(0, 0, 0, 0));
    rd_chk(4'h2, 32'h0);
    rd_chk(`ASR_OFS_DATA, 32'h0);
    wr(`ASR_OFS_BAUD, 32'h1);
    rd_chk(`ASR_OFS_BAUD, 32'h1);
  endtask : t_reset_values

  task automatic t_basic();
    wr(`ASR_OFS_CTRL, C_EN);
    asr_line_model_i.send(9'h0A5, 1'b0, 1'b1);
    rd_chk(`ASR_OFS_STATUS, st(1, 0, 0, 0));
    check({31'h0, irq}, 32'h0);
    wr(`ASR_OFS_CTRL, C_EN | C_MSK | C_GIE);
    @(posedge clk_sys_in);
    check({31'h0, irq}, 32'h1);
    wr(`ASR_OFS_CTRL, C_EN | C_MSK);
    @(posedge clk_sys_in);
    check({31'h0, irq}, 32'h0);
    wr(`ASR_OFS_STATUS, 32'h0);
    rd_chk(`ASR_OFS_STATUS, st(1, 0, 0, 0));
    rd_chk(`ASR_OFS_DATA, 32'hA5);
    rd_chk(`ASR_OFS_STATUS, st(0, 0, 0, 0));
    rd_chk(`ASR_OFS_DATA, 32'h0);
  endtask : t_basic

  task automatic t_glitch();
    asr_line_model_i.glitch(8);
    rd_chk(`ASR_OFS_STATUS, st(0, 0, 0, 0));
    asr_line_model_i.send(9'h05A, 1'b0, 1'b1);
    rd_chk(`ASR_OFS_DATA, 32'h5A);
  endtask : t_glitch

  task automatic t_framing();
    asr_line_model_i.send(9'h03C, 1'b0, 1'b0);
    asr_line_model_i.send(9'h0C3, 1'b0, 1'b1);
    rd_chk(`ASR_OFS_STATUS, st(1, 1, 0, 0));
    rd_chk(`ASR_OFS_DATA, 32'h3C);
    rd_chk(`ASR_OFS_STATUS, st(1, 0, 0, 0));
    rd_chk(`ASR_OFS_DATA, 32'hC3);
    asr_line_model_i.send(9'h077, 1'b0, 1'b0);
    wr(`ASR_OFS_CTRL, C_PE);
    rd_chk(`ASR_OFS_STATUS, st(0, 1, 0, 0));
    wr(`ASR_OFS_CTRL, 32'h0);
    wr(`ASR_OFS_CTRL, C_EN);
    rd_chk(`ASR_OFS_STATUS, st(0, 0, 0, 0));
  endtask : t_framing

  task automatic t_overrun();
    asr_line_model_i.send(9'h011, 1'b0, 1'b1);
    asr_line_model_i.send(9'h022, 1'b0, 1'b1);
    asr_line_model_i.send(9'h033, 1'b0, 1'b1);
    rd_chk(`ASR_OFS_STATUS, st(1, 0, 1, 0));
    rd_chk(`ASR_OFS_DATA, 32'h11);
    asr_line_model_i.send(9'h044, 1'b0, 1'b1);
    rd_chk(`ASR_OFS_DATA, 32'h22);
    rd_chk(`ASR_OFS_STATUS, st(0, 0, 1, 0));
    wr(`ASR_OFS_CTRL, C_PE);
    wr(`ASR_OFS_CTRL, C_EN);
    rd_chk(`ASR_OFS_STATUS, st(0, 0, 0, 0));
    asr_line_model_i.send(9'h055, 1'b0, 1'b1);
    rd_chk(`ASR_OFS_DATA, 32'h55);
  endtask : t_overrun

  // Synchronous mode selected: the character must not land in the FIFO
  task automatic t_sync_mode();
    wr(`ASR_OFS_CTRL, C_EN | C_SY);
    asr_line_model_i.send(9'h066, 1'b0, 1'b1);
    rd_chk(`ASR_OFS_STATUS, st(0, 0, 0, 0));
    wr(`ASR_OFS_CTRL, C_EN);
    rd_chk(`ASR_OFS_STATUS, st(0, 0, 0, 0));
    rd_chk(`ASR_OFS_DATA, 32'h0);
  endtask : t_sync_mode

  task automatic t_nine_addr();
    wr(`ASR_OFS_CTRL, C_EN | C_9 | C_AD);
    asr_line_model_i.send(9'h0AB, 1'b1, 1'b1);
    asr_line_model_i.send(9'h1CD, 1'b1, 1'b1);
    rd_chk(`ASR_OFS_STATUS, st(1, 0, 0, 1));
    rd_chk(`ASR_OFS_DATA, 32'hCD);
    rd_chk(`ASR_OFS_STATUS, st(0, 0, 0, 0));
    wr(`ASR_OFS_CTRL, C_EN | C_9);
    asr_line_model_i.send(9'h012, 1'b1, 1'b1);
    rd_chk(`ASR_OFS_STATUS, st(1, 0, 0, 0));
    rd_chk(`ASR_OFS_DATA, 32'h12);
  endtask : t_nine_addr

  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // Main sequence: reset, then each scenario in turn
  initial begin
    reset_n_in = 1'b0;
    address    = 4'h0;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = 32'h0;
    err_count  = 0;
    compares   = 0;
    cycles     = 0;
    repeat (5) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    t_reset_values();
    t_basic();
    t_glitch();
    t_framing();
    t_overrun();
    t_sync_mode();
    t_nine_addr();
    results();
  end
endmodule : test_async_serial_receiver
